/* rtl/sfbp_defines.vh */
// Constants for the basic flash parameter table store
`ifndef SFBP_DEFINES_VH
`define SFBP_DEFINES_VH

// Command and table placement
`define SFBP_OP_TABLE_READ      8'h5A
`define SFBP_PARAM_TABLE_PTR    24'h00_0030
`define SFBP_TABLE_END          24'h00_0054
`define SFBP_TABLE_DWORDS       4'h9
`define SFBP_BLANK_BYTE         8'hFF

// Link framing
`define SFBP_CMD_BITS_LAST      3'h7
`define SFBP_ADDR_BITS_LAST     5'h17
`define SFBP_DUMMY_BITS_LAST    3'h7
`define SFBP_BYTE_BITS_LAST     3'h7

// Synchroniser reset levels: {sck, cs_n, si}
`define SFBP_SYNC_RST           3'h2

// First double word, field values
`define SFBP_ERASE_4K_AVAIL     2'h1
`define SFBP_WR_GRAN_64         1'h1
`define SFBP_STATUS_NONVOL      1'h0
`define SFBP_WREN_SEL_NONE      1'h0
`define SFBP_UNUSED_3           3'h7
`define SFBP_ERASE_4K_OP        8'h20
`define SFBP_FR_112_SUP         1'h1
`define SFBP_ADDR_3BYTE         2'h0
`define SFBP_DTR_NONE           1'h0
`define SFBP_FR_122_SUP         1'h1
`define SFBP_FR_144_SUP         1'h1
`define SFBP_FR_114_SUP         1'h1
`define SFBP_UNUSED_1           1'h1
`define SFBP_UNUSED_BYTE        8'hFF

// Flash density, bits minus one
`define SFBP_DENSITY_RST        32'h003F_FFFF

// Fast read entries: dummy clocks, mode bits, opcode
`define SFBP_Q144_WAIT          5'h04
`define SFBP_Q144_MODE          3'h2
`define SFBP_Q144_OP            8'hEB
`define SFBP_Q114_WAIT          5'h08
`define SFBP_Q114_MODE          3'h0
`define SFBP_Q114_OP            8'h6B
`define SFBP_D112_WAIT          5'h08
`define SFBP_D112_MODE          3'h0
`define SFBP_D112_OP            8'h3B
`define SFBP_D122_WAIT          5'h00
`define SFBP_D122_MODE          3'h4
`define SFBP_D122_OP            8'hBB

// All-dual and all-quad modes, absent
`define SFBP_FR_222_SUP         1'h0
`define SFBP_FR_444_SUP         1'h0
`define SFBP_NOWAIT_BYTE        8'h00
`define SFBP_ABSENT_OP          8'hFF

// Sector erase types: size exponent and opcode
`define SFBP_ERASE1_SIZE        8'h0C
`define SFBP_ERASE1_OP          8'h20
`define SFBP_ERASE2_SIZE        8'h0F
`define SFBP_ERASE2_OP          8'h52
`define SFBP_ERASE3_SIZE        8'h10
`define SFBP_ERASE3_OP          8'hD8
`define SFBP_ERASE4_SIZE        8'h08
`define SFBP_ERASE4_OP          8'h81

`endif

/* rtl/sfbp_sync.v */
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module sfbp_sync #(
    parameter         W   = 3,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    // Clock and reset
    input  wire         clk,
    input  wire         resetn,
    // Asynchronous levels in, synchronised out
    input  wire [W-1:0] d_in,
    output wire [W-1:0] q_out
);

    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    always @(posedge clk) begin
        if (!resetn) begin
            meta_r <= RST;
            sync_r <= RST;
        end else begin
            meta_r <= d_in;
            sync_r <= meta_r;
        end
    end

    assign q_out = sync_r;

endmodule

/* rtl/sfbp_fifo.v */
// Synchronous FIFO with valid/ready on both sides and a flush
`timescale 1ns/1ps
module sfbp_fifo #(
    parameter W     = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset
    input  wire         clk,
    input  wire         resetn,
    input  wire         flush,
    // Fill side
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    // Drain side
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);

    reg  [W-1:0] mem_r [0:DEPTH-1];
    reg  [AW:0]  wr_ptr_r;
    reg  [AW:0]  rd_ptr_r;
    wire [AW:0]  level;
    wire         push;
    wire         pop;

    assign level     = wr_ptr_r - rd_ptr_r;
    assign in_ready  = (level != DEPTH[AW:0]);
    assign out_valid = (level != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_r[rd_ptr_r[AW-1:0]];

    // Pointer ring relies on DEPTH being a power of two
    always @(posedge clk) begin
        if (!resetn || flush) begin
            wr_ptr_r <= {(AW+1){1'b0}};
            rd_ptr_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

    always @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

endmodule

/* rtl/sfbp_param_rom.v */
// Basic flash parameter table store behind the serial read link
`timescale 1ns/1ps
`include "sfbp_defines.vh"
module sfbp_param_rom #(
    parameter [31:0] DENSITY    = `SFBP_DENSITY_RST,
    parameter        FIFO_DEPTH = 8,
    parameter        FIFO_AW    = 3
) (
    // Clock and reset
    input  wire        clk,
    input  wire        resetn,
    // Serial link pins
    input  wire        sck_in,
    input  wire        cs_n_in,
    input  wire        si_in,
    output wire        so_out,
    output wire        so_oe_n,
    // Status
    output wire        table_read_active,
    output wire        cmd_ignored,
    output wire [23:0] out_addr
);

    localparam [2:0] ST_CMD    = 3'h0;
    localparam [2:0] ST_ADDR   = 3'h1;
    localparam [2:0] ST_DUMMY  = 3'h2;
    localparam [2:0] ST_DATA   = 3'h3;
    localparam [2:0] ST_IGNORE = 3'h4;

    // Table contents, little-endian double words
    wire [31:0] dw0;
    wire [31:0] dw2;
    wire [31:0] dw3;
    wire [31:0] dw4;
    wire [31:0] dw5;
    wire [31:0] dw6;
    wire [31:0] dw7;
    wire [31:0] dw8;

    assign dw0[1:0]   = `SFBP_ERASE_4K_AVAIL;
    assign dw0[2]     = `SFBP_WR_GRAN_64;
    assign dw0[3]     = `SFBP_STATUS_NONVOL;
    assign dw0[4]     = `SFBP_WREN_SEL_NONE;
    assign dw0[7:5]   = `SFBP_UNUSED_3;
    assign dw0[15:8]  = `SFBP_ERASE_4K_OP;
    assign dw0[16]    = `SFBP_FR_112_SUP;
    assign dw0[18:17] = `SFBP_ADDR_3BYTE;
    assign dw0[19]    = `SFBP_DTR_NONE;
    assign dw0[20]    = `SFBP_FR_122_SUP;
    assign dw0[21]    = `SFBP_FR_144_SUP;
    assign dw0[22]    = `SFBP_FR_114_SUP;
    assign dw0[23]    = `SFBP_UNUSED_1;
    assign dw0[31:24] = `SFBP_UNUSED_BYTE;

    assign dw2 = {`SFBP_Q114_OP, `SFBP_Q114_MODE, `SFBP_Q114_WAIT,
                  `SFBP_Q144_OP, `SFBP_Q144_MODE, `SFBP_Q144_WAIT};
    assign dw3 = {`SFBP_D122_OP, `SFBP_D122_MODE, `SFBP_D122_WAIT,
                  `SFBP_D112_OP, `SFBP_D112_MODE, `SFBP_D112_WAIT};
    assign dw4 = {`SFBP_UNUSED_BYTE, `SFBP_UNUSED_BYTE, `SFBP_UNUSED_BYTE,
                  `SFBP_UNUSED_3, `SFBP_FR_444_SUP, `SFBP_UNUSED_3,
                  `SFBP_FR_222_SUP};
    assign dw5 = {`SFBP_ABSENT_OP, `SFBP_NOWAIT_BYTE,
                  `SFBP_UNUSED_BYTE, `SFBP_UNUSED_BYTE};
    assign dw6 = {`SFBP_ABSENT_OP, `SFBP_NOWAIT_BYTE,
                  `SFBP_UNUSED_BYTE, `SFBP_UNUSED_BYTE};
    assign dw7 = {`SFBP_ERASE2_OP, `SFBP_ERASE2_SIZE,
                  `SFBP_ERASE1_OP, `SFBP_ERASE1_SIZE};
    assign dw8 = {`SFBP_ERASE4_OP, `SFBP_ERASE4_SIZE,
                  `SFBP_ERASE3_OP, `SFBP_ERASE3_SIZE};

    // Byte lookup; outside the table the link reads blank
    function [7:0] table_byte;
        input [23:0] addr;
        reg   [23:0] rel;
        reg   [31:0] dw;
        begin
            rel = addr - `SFBP_PARAM_TABLE_PTR;
            case (rel[5:2])
                4'h0:    dw = dw0;
                4'h1:    dw = DENSITY;
                4'h2:    dw = dw2;
                4'h3:    dw = dw3;
                4'h4:    dw = dw4;
                4'h5:    dw = dw5;
                4'h6:    dw = dw6;
                4'h7:    dw = dw7;
                4'h8:    dw = dw8;
                default: dw = {4{`SFBP_BLANK_BYTE}};
            endcase
            if (addr < `SFBP_PARAM_TABLE_PTR || addr >= `SFBP_TABLE_END) begin
                table_byte = `SFBP_BLANK_BYTE;
            end else begin
                table_byte = dw[{rel[1:0], 3'h0} +: 8];
            end
        end
    endfunction

    // Pin synchronisation and edge detection
    wire [2:0] sync_q;
    wire       sck_s;
    wire       cs_n_s;
    wire       si_s;
    reg        sck_prev_r;
    wire       sck_rise;

    sfbp_sync #(
        .W   (3),
        .RST (`SFBP_SYNC_RST)
    ) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .d_in   ({sck_in, cs_n_in, si_in}),
        .q_out  (sync_q)
    );

    assign sck_s    = sync_q[2];
    assign cs_n_s   = sync_q[1];
    assign si_s     = sync_q[0];
    assign sck_rise = sck_s & ~sck_prev_r;

    // Framing state
    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg  [2:0]  bit_cnt_r;
    reg  [4:0]  addr_cnt_r;
    reg  [7:0]  cmd_r;
    reg  [23:0] addr_r;
    wire [7:0]  cmd_shift;
    wire [23:0] addr_shift;
    wire        addr_done;
    wire        dummy_done;

    assign cmd_shift  = {cmd_r[6:0], si_s};
    assign addr_shift = {addr_r[22:0], si_s};
    assign addr_done  = sck_rise && state_r == ST_ADDR
                        && addr_cnt_r == `SFBP_ADDR_BITS_LAST;
    assign dummy_done = sck_rise && state_r == ST_DUMMY
                        && bit_cnt_r == `SFBP_DUMMY_BITS_LAST;

    always @* begin
        state_nxt = state_r;
        if (cs_n_s) begin
            state_nxt = ST_CMD;
        end else if (sck_rise) begin
            case (state_r)
                ST_CMD: begin
                    if (bit_cnt_r == `SFBP_CMD_BITS_LAST) begin
                        if (cmd_shift == `SFBP_OP_TABLE_READ) begin
                            state_nxt = ST_ADDR;
                        end else begin
                            state_nxt = ST_IGNORE;
                        end
                    end
                end
                ST_ADDR: begin
                    if (addr_done) begin
                        state_nxt = ST_DUMMY;
                    end
                end
                ST_DUMMY: begin
                    if (dummy_done) begin
                        state_nxt = ST_DATA;
                    end
                end
                default: state_nxt = state_r;
            endcase
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            state_r    <= ST_CMD;
            sck_prev_r <= 1'b0;
            bit_cnt_r  <= 3'h0;
            addr_cnt_r <= 5'h00;
            cmd_r      <= 8'h00;
            addr_r     <= 24'h00_0000;
        end else begin
            state_r    <= state_nxt;
            sck_prev_r <= sck_s;
            if (cs_n_s) begin
                bit_cnt_r  <= 3'h0;
                addr_cnt_r <= 5'h00;
            end else if (sck_rise) begin
                case (state_r)
                    ST_CMD: begin
                        cmd_r     <= cmd_shift;
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                    end
                    ST_ADDR: begin
                        addr_r     <= addr_shift;
                        addr_cnt_r <= addr_cnt_r + 5'h01;
                    end
                    ST_DUMMY: begin
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                    end
                    default: bit_cnt_r <= bit_cnt_r;
                endcase
            end
        end
    end

    // Prefetch into the FIFO; the dummy byte hides the fill latency
    reg  [23:0] fill_addr_r;
    reg         fill_on_r;
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire        fifo_out_ready;
    wire [7:0]  fifo_out_data;
    wire        push;

    assign push = fill_on_r & fifo_in_ready & ~cs_n_s;

    always @(posedge clk) begin
        if (!resetn) begin
            fill_on_r   <= 1'b0;
            fill_addr_r <= 24'h00_0000;
        end else if (cs_n_s) begin
            fill_on_r <= 1'b0;
        end else if (addr_done) begin
            fill_on_r   <= 1'b1;
            fill_addr_r <= addr_shift;
        end else if (push) begin
            fill_addr_r <= fill_addr_r + 24'h00_0001;
        end
    end

    sfbp_fifo #(
        .W     (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .flush     (cs_n_s),
        .in_valid  (fill_on_r & ~cs_n_s),
        .in_ready  (fifo_in_ready),
        .in_data   (table_byte(fill_addr_r)),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // Output shifter: bits change just after the rising edge the host sampled on,
    // which leaves most of a link period of setup for the next rising edge
    reg  [6:0]  out_sh_r;
    reg  [2:0]  out_cnt_r;
    reg         so_r;
    reg         so_oe_n_r;
    reg  [23:0] out_addr_r;
    reg  [23:0] next_addr_r;
    reg         ignored_r;
    wire        load_evt;
    wire        shift_evt;
    wire [7:0]  load_byte;

    assign load_evt  = dummy_done || (sck_rise && state_r == ST_DATA
                       && out_cnt_r == `SFBP_BYTE_BITS_LAST);
    assign shift_evt = sck_rise && state_r == ST_DATA
                       && out_cnt_r != `SFBP_BYTE_BITS_LAST;
    assign fifo_out_ready = load_evt & ~cs_n_s;
    // Starvation cannot occur at the link rate; blank keeps the line defined
    assign load_byte = fifo_out_valid ? fifo_out_data : `SFBP_BLANK_BYTE;

    always @(posedge clk) begin
        if (!resetn) begin
            so_r        <= 1'b1;
            so_oe_n_r   <= 1'b1;
            out_sh_r    <= 7'h7F;
            out_cnt_r   <= 3'h0;
            out_addr_r  <= 24'h00_0000;
            next_addr_r <= 24'h00_0000;
        end else if (cs_n_s) begin
            so_oe_n_r <= 1'b1;
            out_cnt_r <= 3'h0;
        end else if (addr_done) begin
            next_addr_r <= addr_shift;
        end else if (load_evt) begin
            so_r        <= load_byte[7];
            out_sh_r    <= load_byte[6:0];
            so_oe_n_r   <= 1'b0;
            out_cnt_r   <= 3'h0;
            out_addr_r  <= next_addr_r;
            next_addr_r <= next_addr_r + 24'h00_0001;
        end else if (shift_evt) begin
            so_r      <= out_sh_r[6];
            out_sh_r  <= {out_sh_r[5:0], 1'b1};
            out_cnt_r <= out_cnt_r + 3'h1;
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            ignored_r <= 1'b0;
        end else begin
            ignored_r <= (state_r == ST_IGNORE);
        end
    end

    assign so_out            = so_r;
    assign so_oe_n           = so_oe_n_r;
    assign table_read_active = ~so_oe_n_r;
    assign cmd_ignored       = ignored_r;
    assign out_addr          = out_addr_r;

endmodule

/* bench/sfbp_param_rom_sva.sv */
// Concurrent checks on the parameter table store pins
`timescale 1ns/1ps
module sfbp_param_rom_sva (
    // Clock and reset
    input wire        clk,
    input wire        resetn,
    // Serial link pins
    input wire        sck_in,
    input wire        cs_n_in,
    input wire        si_in,
    input wire        so_out,
    input wire        so_oe_n,
    // Status
    input wire        table_read_active,
    input wire        cmd_ignored,
    input wire [23:0] out_addr
);
    reg        sck_q_r;
    reg  [3:0] since_r;
    wire [3:0] since_nxt;

    // Raw pin edge, so the count runs ahead of the block's own synchroniser
    assign since_nxt = (sck_in && !sck_q_r) ? 4'h0 :
                       ((since_r == 4'hF) ? since_r : since_r + 4'h1);

    always @(posedge clk) begin
        if (!resetn) begin
            sck_q_r <= 1'b0;
            since_r <= 4'hF;
        end else begin
            sck_q_r <= sck_in;
            since_r <= since_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence cs_idle6;
        cs_n_in[*6];
    endsequence

    // Outputs move only a few cycles after a link clock rise
    sequence after_rise;
        since_r >= 4'h1 && since_r <= 4'h5;
    endsequence

    reset_state_a: assert property ($rose(resetn) |-> so_out && so_oe_n
        && !table_read_active && !cmd_ignored && out_addr == 24'h00_0000)
        else $error("outputs not at rest after reset");
    active_mirror_a: assert property ((table_read_active == !so_oe_n)
        && !(table_read_active && cmd_ignored))
        else $error("active flag disagrees with output enable");
    release_quiet_a: assert property (cs_idle6 |-> so_oe_n && !cmd_ignored)
        else $error("output still driven after deselect");
    refused_silent_a: assert property (cmd_ignored |-> so_oe_n)
        else $error("output driven for a foreign opcode");
    drive_start_a: assert property ($fell(so_oe_n) |-> after_rise ##0 !cs_n_in)
        else $error("output enabled away from a clock rise");
    bit_pace_a: assert property (!so_oe_n && $past(!so_oe_n) && $changed(so_out)
        |-> after_rise)
        else $error("data bit moved between clock rises");
    addr_step_a: assert property (!so_oe_n && $past(!so_oe_n) && $changed(out_addr)
        |-> after_rise ##0 out_addr == $past(out_addr) + 24'h00_0001)
        else $error("byte address did not step by one");
    blank_fill_a: assert property (!so_oe_n
        && (out_addr < 24'h00_0030 || out_addr > 24'h00_0053) |-> so_out)
        else $error("byte outside the table not all ones");
endmodule

bind sfbp_param_rom sfbp_param_rom_sva sfbp_param_rom_sva_i (
    .clk(clk), .resetn(resetn), .sck_in(sck_in), .cs_n_in(cs_n_in), .si_in(si_in),
    .so_out(so_out), .so_oe_n(so_oe_n), .table_read_active(table_read_active),
    .cmd_ignored(cmd_ignored), .out_addr(out_addr)
);

/* bench/sfbp_host_model.sv */
// Host side of the serial link: frames a table read and collects bytes
`timescale 1ns/1ps
module sfbp_host_model (
    // Link pins
    output logic sck,
    output logic cs_n,
    output logic si,
    input  wire  so_out,
    input  wire  so_oe_n
);
    logic [7:0] rx_q [$];
    logic       oe_seen;

    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b1;
        oe_seen = 1'b0;
    end

    // Mode 0, clock still outside frames; half period in ns
    // Half must be a whole number of clk periods, so pins move on a clk rise
    task automatic frame(input logic [7:0] op, input logic [23:0] addr,
                         input int nbits, input int half);
        logic [39:0] hdr;
        logic [7:0]  sh;
        hdr = {op, addr, 8'h00};
        rx_q.delete();
        oe_seen = 1'b0;
        sh = 8'h00;
        cs_n <= 1'b0;
        #(half);
        for (int i = 0; i < 40 + nbits; i++) begin
            // Data phase input is don't-care, so keep it wandering
            si <= (i < 40) ? hdr[39 - i] : ~si;
            #(half);
            sck <= 1'b1;
            if (i >= 40) begin
                // Released line floats high on its pull-up
                sh = {sh[6:0], so_oe_n | so_out};
                if (!so_oe_n)
                    oe_seen = 1'b1;
                if ((i - 40) % 8 == 7)
                    rx_q.push_back(sh);
            end
            #(half);
            sck <= 1'b0;
        end
        si <= ~si;
        cs_n <= 1'b1;
        #(2 * half);
    endtask
endmodule

/* bench/test_sfbp_param_rom.sv */
// Self-checking bench for the parameter table store
`timescale 1ns/1ps
module test_sfbp_param_rom;
    `define SFBP_CHK(what, exp, got) \
        begin \
            n_compared++; \
            if ((got) !== (exp)) begin \
                errors++; \
                $display("BAD %s expected %h seen %h", what, exp, got); \
            end \
        end
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    wire         sck;
    wire         cs_n;
    wire         si;
    wire         so_out;
    wire         so_oe_n;
    wire         active;
    wire         ignored;
    wire  [23:0] out_addr;
    int          errors = 0;
    int          n_compared = 0;
    int          cycles = 0;
    logic [7:0]  bad_ops [0:4] = '{8'h03, 8'h0B, 8'h5B, 8'hA5, 8'h00};
    logic [7:0]  exp_tab [0:35] = '{
        8'hE5, 8'h20, 8'hF1, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h00, 8'h44, 8'hEB, 8'h08, 8'h6B,
        8'h08, 8'h3B, 8'h80, 8'hBB, 8'hEE, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF,
        8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h0C, 8'h20, 8'h0F, 8'h52, 8'h10, 8'hD8, 8'h08, 8'h81};

    sfbp_param_rom sfbp_param_rom_i (
        .clk(clk), .resetn(resetn), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
        .so_out(so_out), .so_oe_n(so_oe_n), .table_read_active(active),
        .cmd_ignored(ignored), .out_addr(out_addr));
    sfbp_host_model sfbp_host_model_i (
        .sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe_n(so_oe_n));

    always #20 clk = ~clk;

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end

    function automatic logic [7:0] exp_byte(input logic [23:0] a);
        if (a >= 24'h00_0030 && a <= 24'h00_0053)
            return exp_tab[a - 24'h00_0030];
        return 8'hFF;
    endfunction

    // Status is looked at two bits into the data phase
    task automatic run(input logic [7:0] op, input logic [23:0] addr, input int nbits,
                       input int half, input logic exp_act);
        fork
            sfbp_host_model_i.frame(op, addr, nbits, half);
            begin
                #(half * 85);
                `SFBP_CHK("active", exp_act, active)
                `SFBP_CHK("ignored", ~exp_act, ignored)
            end
        join
        `SFBP_CHK("oe after frame", 1'b1, so_oe_n)
        `SFBP_CHK("oe seen", exp_act, sfbp_host_model_i.oe_seen)
    endtask

    task automatic expect_bytes(input string name, input logic [23:0] first, input int n);
        `SFBP_CHK(name, n, sfbp_host_model_i.rx_q.size())
        for (int i = 0; i < n && i < sfbp_host_model_i.rx_q.size(); i++) begin
            `SFBP_CHK(name, exp_byte(first + i), sfbp_host_model_i.rx_q[i])
        end
        $display("test %s done", name);
    endtask

    initial begin
        repeat (19) @(posedge clk);
        @(negedge clk);
        `SFBP_CHK("reset oe", 1'b1, so_oe_n)
        `SFBP_CHK("reset so", 1'b1, so_out)
        `SFBP_CHK("reset addr", 24'h00_0000, out_addr)
        @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        $display("test reset done");
        run(8'h5A, 24'h00_0030, 37 * 8, 160, 1'b1);
        expect_bytes("whole table", 24'h00_0030, 37);
        // Slow host lets the prefetch buffer back up
        run(8'h5A, 24'h00_004E, 6 * 8, 480, 1'b1);
        expect_bytes("erase types", 24'h00_004E, 6);
        run(8'h5A, 24'h00_002E, 3 * 8, 160, 1'b1);
        expect_bytes("table edge", 24'h00_002E, 3);
        for (int k = 0; k < 5; k++) begin
            run(bad_ops[k], 24'h00_0030, 16, 160, 1'b0);
        end
        $display("test foreign opcodes done");
        run(8'h5A, 24'h00_0038, 12, 160, 1'b1);
        expect_bytes("cut frame", 24'h00_0038, 1);
        run(8'h5A, 24'h00_0039, 8, 160, 1'b1);
        expect_bytes("after cut", 24'h00_0039, 1);
        give_verdict();
    end
endmodule
